/* File: src/ecp_pkg.sv */
// constants, mode codes and handshake states of the parallel port controller
package ecp_pkg;

  localparam int CLK_PERIOD_NS = 25;
  // least data setup before the strobe, least strobe width
  localparam int SETUP_NS = 500;
  localparam int STROBE_NS = 500;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int FIFO_DEPTH = 16;

  localparam logic [10:0] OFS_DATA = 11'h000;
  localparam logic [10:0] OFS_STATUS = 11'h001;
  localparam logic [10:0] OFS_CONTROL = 11'h002;
  localparam logic [10:0] OFS_FIFO = 11'h400;
  localparam logic [10:0] OFS_CFGB = 11'h401;
  localparam logic [10:0] OFS_XCTL = 11'h402;

  localparam logic [2:0] MODE_SPP = 3'h0;
  localparam logic [2:0] MODE_PS2 = 3'h1;
  localparam logic [2:0] MODE_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_EPP = 3'h4;
  localparam logic [2:0] MODE_RSVD = 3'h5;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG = 3'h7;

  localparam int XCTL_MODE_LSB = 5;
  localparam int XCTL_LOW_LSB = 2;
  localparam int XCTL_FULL = 1;
  localparam int XCTL_EMPTY = 0;

  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELIN = 3;
  localparam int CTL_DIR = 5;

  localparam logic [2:0] MODE_RESET = MODE_SPP;
  localparam logic [2:0] XCTL_LOW_RESET = 3'h1;
  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CFGA_VALUE = 8'h10;
  localparam logic [7:0] CFGB_VALUE = 8'h00;

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_SETUP,
    HS_STROBE,
    HS_DONE,
    HS_REV_REQ,
    HS_REV_REL
  } hs_state_e;

endpackage : ecp_pkg

/* File: src/ecp_port_mode_control.sv */
// mode control, fifo and automatic handshakes of the extended parallel port
`timescale 1ns/1ps

module ecp_port_mode_control
  import ecp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [10:0] ioAddr,
  input wire logic ioRd,
  input wire logic ioWr,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  input wire logic eppOptionEn,
  output logic eppSelected,
  input wire logic [7:0] pdIn,
  output logic [7:0] pdOut,
  output logic pdOe_n,
  input wire logic busyIn,
  input wire logic ackIn_n,
  input wire logic faultIn_n,
  input wire logic slctIn,
  input wire logic pErrorIn,
  output logic strobeOut_n,
  output logic strobeOe_n,
  output logic autoFdOut_n,
  output logic autoFdOe_n,
  output logic initOut_n,
  output logic initOe_n,
  output logic selectInOut_n,
  output logic selectInOe_n
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);

  function automatic logic isBasic(input logic [2:0] m);
    return (m == MODE_SPP) || (m == MODE_PS2);
  endfunction : isBasic

  // pin synchronisers
  logic [7:0] pdMetaReg, pdSyncReg;
  logic [4:0] stMetaReg, stSyncReg;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pdMetaReg <= 8'h00;
      pdSyncReg <= 8'h00;
      stMetaReg <= 5'h00;
      stSyncReg <= 5'h00;
    end else begin
      pdMetaReg <= pdIn;
      pdSyncReg <= pdMetaReg;
      stMetaReg <= {busyIn, ackIn_n, faultIn_n, slctIn, pErrorIn};
      stSyncReg <= stMetaReg;
    end
  end
  logic busyS, ackS_n, faultS_n, slctS, pErrS;
  assign {busyS, ackS_n, faultS_n, slctS, pErrS} = stSyncReg;

  logic [2:0] modeReg, xctlLowReg;
  logic [5:0] ctlReg;
  logic [7:0] dataReg, lastReadReg;
  logic [8:0] fifoMem [DEPTH];
  logic [PTR_W-1:0] wrPtrReg, rdPtrReg;
  logic [PTR_W:0] countReg;
  logic [6:0] rleCntReg;
  logic rleArmedReg;
  logic [7:0] rptLeftReg, rptByteReg;
  hs_state_e hsStateReg;
  logic [4:0] hsCntReg;
  logic strobeLowReg, hostAckReg, txTagReg;
  logic [7:0] txByteReg;
  logic rxValidReg, rxTagReg;
  logic [7:0] rxByteReg;

  logic fullFlag, emptyFlag, dirReg, dirEff, autoFwd, autoRev;
  logic xctlWr, modeOk, flushReq, fifoClear;
  logic [2:0] newMode;
  logic busPush, busPop, hsPop, rptPush, push, pop;
  logic [8:0] fifoHead, pushWord;

  assign fullFlag = countReg == FULL_COUNT;
  assign emptyFlag = countReg == '0;
  assign dirReg = ctlReg[CTL_DIR];
  // direction has no effect in 000 and 010
  assign dirEff = dirReg && modeReg != MODE_SPP && modeReg != MODE_FIFO;
  assign autoFwd = modeReg == MODE_FIFO || (modeReg == MODE_ECP && !dirReg);
  assign autoRev = modeReg == MODE_ECP && dirReg;

  assign xctlWr = ioWr && ioAddr == OFS_XCTL;
  assign newMode = ioWrData[XCTL_MODE_LSB +: 3];
  assign modeOk = isBasic(modeReg) || isBasic(newMode);
  // bytes caught after software stopped reading are thrown away
  assign flushReq = xctlWr && modeOk && autoRev
                    && newMode != MODE_ECP;
  assign fifoClear = modeReg == MODE_SPP || flushReq;

  // mode and extended control bits
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      modeReg <= MODE_RESET;
      xctlLowReg <= XCTL_LOW_RESET;
    end else if (xctlWr) begin
      if (modeOk) begin
        modeReg <= newMode;
      end
      xctlLowReg <= ioWrData[XCTL_LOW_LSB +: 3];
    end
  end

  // device control and data registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctlReg <= CTL_RESET;
      dataReg <= DATA_RESET;
    end else begin
      if (ioWr && ioAddr == OFS_CONTROL) begin
        ctlReg[4:0] <= ioWrData[4:0];
        if (modeReg == MODE_PS2) begin
          ctlReg[CTL_DIR] <= ioWrData[CTL_DIR];
        end
      end
      // offset zero is the command queue in mode 011
      if (ioWr && ioAddr == OFS_DATA && modeReg != MODE_ECP) begin
        dataReg <= ioWrData;
      end
    end
  end

  // a full fifo drops the write rather than stalling the host
  assign busPush = ioWr && !fullFlag && !autoRev && (
      (ioAddr == OFS_FIFO && (autoFwd || modeReg == MODE_TEST))
      || (ioAddr == OFS_DATA && modeReg == MODE_ECP));
  assign busPop = ioRd && ioAddr == OFS_FIFO && !emptyFlag
                  && (modeReg == MODE_TEST || autoRev);
  assign hsPop = hsStateReg == HS_IDLE && autoFwd && !emptyFlag
                 && !busyS && !fifoClear;
  assign rptPush = rptLeftReg != 8'h00 && !fullFlag;
  assign push = busPush || rptPush;
  assign pop = busPop || hsPop;
  assign fifoHead = fifoMem[rdPtrReg];
  // tag bit one is data, zero is a command byte
  assign pushWord = busPush ? {ioAddr == OFS_FIFO, ioWrData}
                            : {1'b1, rptByteReg};

  always_ff @(posedge core_clk) begin
    if (push) begin
      fifoMem[wrPtrReg] <= pushWord;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n || fifoClear) begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      countReg <= '0;
    end else begin
      if (push) begin
        wrPtrReg <= wrPtrReg + 1'b1;
      end
      if (pop) begin
        rdPtrReg <= rdPtrReg + 1'b1;
      end
      if (push && !pop) begin
        countReg <= countReg + 1'b1;
      end else if (pop && !push) begin
        countReg <= countReg - 1'b1;
      end
    end
  end

  // test mode re-reads the last byte when empty
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lastReadReg <= 8'h00;
    end else if (busPop) begin
      lastReadReg <= fifoHead[7:0];
    end
  end

  // reverse run-length expansion
  always_ff @(posedge core_clk) begin
    if (!reset_n || fifoClear) begin
      rleCntReg <= 7'h00;
      rleArmedReg <= 1'b0;
      rptLeftReg <= 8'h00;
      rptByteReg <= 8'h00;
    end else if (rxValidReg) begin
      if (!rxTagReg) begin
        // channel addresses are not supported in reverse
        if (!rxByteReg[7]) begin
          rleCntReg <= rxByteReg[6:0];
          rleArmedReg <= 1'b1;
        end
      end else begin
        rptByteReg <= rxByteReg;
        rptLeftReg <= rleArmedReg ? {1'b0, rleCntReg} + 8'h01
                                  : 8'h01;
        rleArmedReg <= 1'b0;
      end
    end else if (rptPush) begin
      rptLeftReg <= rptLeftReg - 8'h01;
    end
  end

  // automatic handshake engine
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hsStateReg <= HS_IDLE;
      hsCntReg <= 5'h00;
      strobeLowReg <= 1'b0;
      hostAckReg <= 1'b1;
      txByteReg <= 8'h00;
      txTagReg <= 1'b1;
      rxValidReg <= 1'b0;
      rxTagReg <= 1'b1;
      rxByteReg <= 8'h00;
    end else begin
      rxValidReg <= 1'b0;
      if (!autoFwd && !autoRev) begin
        // abandon any byte in flight
        hsStateReg <= HS_IDLE;
        strobeLowReg <= 1'b0;
        hostAckReg <= 1'b1;
      end else begin
        unique case (hsStateReg)
          HS_IDLE: begin
            if (hsPop) begin
              txByteReg <= fifoHead[7:0];
              txTagReg <= fifoHead[8];
              hostAckReg <= fifoHead[8];
              hsCntReg <= 5'(SETUP_CYC - 1);
              hsStateReg <= HS_SETUP;
            end else if (autoRev && !fullFlag && rptLeftReg == 8'h00
                         && !rxValidReg) begin
              hostAckReg <= 1'b0;
              hsStateReg <= HS_REV_REQ;
            end
          end
          HS_SETUP: begin
            if (hsCntReg == 5'h00) begin
              strobeLowReg <= 1'b1;
              hsCntReg <= 5'(STROBE_CYC - 1);
              hsStateReg <= HS_STROBE;
            end else begin
              hsCntReg <= hsCntReg - 5'h01;
            end
          end
          HS_STROBE: begin
            // compatible strobe is timed, ECP waits for PeriphAck
            if (modeReg == MODE_FIFO ? hsCntReg == 5'h00 : busyS) begin
              strobeLowReg <= 1'b0;
              hsStateReg <= HS_DONE;
            end else if (hsCntReg != 5'h00) begin
              hsCntReg <= hsCntReg - 5'h01;
            end
          end
          HS_DONE: begin
            if (!busyS) begin
              hsStateReg <= HS_IDLE;
            end
          end
          HS_REV_REQ: begin
            if (!ackS_n) begin
              rxByteReg <= pdSyncReg;
              rxTagReg <= busyS;
              rxValidReg <= 1'b1;
              hostAckReg <= 1'b1;
              hsStateReg <= HS_REV_REL;
            end
          end
          HS_REV_REL: begin
            if (ackS_n) begin
              hsStateReg <= HS_IDLE;
            end
          end
        endcase
      end
    end
  end

  // pin levels, registered so mode switches cannot glitch them
  logic stbLvl, afdLvl, ocMode;
  always_comb begin
    stbLvl = !ctlReg[CTL_STROBE];
    afdLvl = !ctlReg[CTL_AUTOFD];
    if (autoFwd || autoRev) begin
      stbLvl = !strobeLowReg;
      if (modeReg == MODE_ECP) begin
        afdLvl = hostAckReg;
      end
    end
    if (modeReg == MODE_RSVD) begin
      stbLvl = 1'b1;
      afdLvl = 1'b1;
    end
  end
  assign ocMode = modeReg == MODE_SPP;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      strobeOut_n <= 1'b1;
      strobeOe_n <= 1'b1;
      autoFdOut_n <= 1'b1;
      autoFdOe_n <= 1'b1;
      initOut_n <= 1'b0;
      initOe_n <= 1'b0;
      selectInOut_n <= 1'b1;
      selectInOe_n <= 1'b1;
      pdOut <= 8'h00;
      pdOe_n <= 1'b0;
      eppSelected <= 1'b0;
    end else begin
      strobeOut_n <= stbLvl;
      autoFdOut_n <= afdLvl;
      initOut_n <= ctlReg[CTL_INIT];
      selectInOut_n <= !ctlReg[CTL_SELIN];
      // open collector only pulls low
      strobeOe_n <= ocMode && stbLvl;
      autoFdOe_n <= ocMode && afdLvl;
      initOe_n <= ocMode && ctlReg[CTL_INIT];
      selectInOe_n <= ocMode && !ctlReg[CTL_SELIN];
      pdOut <= autoFwd ? txByteReg : dataReg;
      pdOe_n <= dirEff;
      eppSelected <= modeReg == MODE_EPP && eppOptionEn;
    end
  end

  logic [7:0] rdMux;
  always_comb begin
    case (ioAddr)
      OFS_DATA: rdMux = dirEff ? pdSyncReg : dataReg;
      OFS_STATUS: rdMux = {!busyS, ackS_n, pErrS, slctS, faultS_n, 3'h0};
      OFS_CONTROL: rdMux = {2'h0, ctlReg};
      OFS_FIFO: begin
        if (modeReg == MODE_CFG) begin
          rdMux = CFGA_VALUE;
        end else if (modeReg == MODE_TEST && emptyFlag) begin
          rdMux = lastReadReg;
        end else begin
          rdMux = fifoHead[7:0];
        end
      end
      OFS_CFGB: rdMux = (modeReg == MODE_CFG) ? CFGB_VALUE : 8'h00;
      OFS_XCTL: rdMux = {modeReg, xctlLowReg, fullFlag, emptyFlag};
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ioRdData <= 8'h00;
    end else if (ioRd) begin
      ioRdData <= rdMux;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_full_hold;
    fullFlag && !pop && !fifoClear |=> fullFlag && countReg == FULL_COUNT;
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("full fifo accepted a byte");

  property p_spp_empty;
    modeReg == MODE_SPP |=> emptyFlag;
  endproperty
  a_spp_empty: assert property (p_spp_empty)
    else $error("fifo not empty in standard mode");

  property p_open_collector;
    modeReg == MODE_SPP |=> strobeOe_n == strobeOut_n
                            && autoFdOe_n == autoFdOut_n;
  endproperty
  a_open_collector: assert property (p_open_collector)
    else $error("control line driven high in standard mode");

  property p_push_pull;
    modeReg != MODE_SPP |=> !strobeOe_n && !autoFdOe_n && !initOe_n;
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("control line not push-pull");

  property p_tristate;
    modeReg == MODE_PS2 && dirReg |=> pdOe_n;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("data lines driven in input direction");

  property p_mode_path;
    modeReg != $past(modeReg) |-> isBasic($past(modeReg)) || isBasic(modeReg);
  endproperty
  a_mode_path: assert property (p_mode_path)
    else $error("illegal mode transition");

  property p_dir_lock;
    modeReg != MODE_PS2 |=> dirReg == $past(dirReg);
  endproperty
  a_dir_lock: assert property (p_dir_lock)
    else $error("direction changed outside mode 001");

  property p_rev_leave;
    autoRev ##1 isBasic(modeReg) |=> autoFdOut_n && emptyFlag;
  endproperty
  a_rev_leave: assert property (p_rev_leave)
    else $error("reverse exit kept nAutoFd or data");

  property p_host_ack;
    hsStateReg == HS_STROBE && modeReg == MODE_ECP
      |=> autoFdOut_n == $past(txTagReg);
  endproperty
  a_host_ack: assert property (p_host_ack)
    else $error("HostAck does not match byte tag");

  property p_rle;
    rxValidReg && rxTagReg && rleArmedReg && !fifoClear
      |=> rptLeftReg == {1'b0, $past(rleCntReg)} + 8'h01;
  endproperty
  a_rle: assert property (p_rle)
    else $error("run length count wrong");

  property p_cfg_read;
    ioRd && ioAddr == OFS_FIFO && modeReg == MODE_CFG
      |=> ioRdData == CFGA_VALUE;
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("configuration register a misread");

  property p_reserved_idle;
    modeReg == MODE_RSVD [*2] |-> strobeOut_n && autoFdOut_n;
  endproperty
  a_reserved_idle: assert property (p_reserved_idle)
    else $error("handshake active in reserved mode");

  c_fwd_byte: cover property (hsStateReg == HS_STROBE
                              ##[1:40] hsStateReg == HS_DONE);
  c_rev_byte: cover property (rxValidReg && rxTagReg);
  c_rle: cover property (rptLeftReg > 8'h01 ##1 rptPush);
  c_mode_back: cover property (autoFwd ##1 isBasic(modeReg));

endmodule : ecp_port_mode_control

/* File: sim/ecp_periph_model.sv */
// behavioural parallel-port peripheral for forward and reverse ECP traffic
`timescale 1ns/1ps

module ecp_periph_model (
  input wire logic core_clk,
  input wire logic strobeLine,
  input wire logic autoFdLine,
  input wire logic pdOe_n,
  input wire logic [7:0] pdOut,
  input wire logic drvEn,
  input wire logic [1:0] revCnt,
  input wire logic [0:2][8:0] revItem,
  input wire logic [7:0] delayCyc,
  output logic busyIn,
  output logic ackIn_n,
  output logic [7:0] pdIn,
  output logic [7:0] fwdByte,
  output logic fwdTag,
  output int fwdCnt,
  output int revSent
);
  logic [7:0] curByte;
  logic [7:0] idlePat = 8'hA5;

  // floating bus never looks stable, so stale values cannot pass
  always @(posedge core_clk) idlePat <= ~idlePat;
  assign pdIn = !pdOe_n ? pdOut : (drvEn ? curByte : idlePat);

  initial begin
    busyIn = 1'b0;
    ackIn_n = 1'b1;
    fwdCnt = 0;
    revSent = 0;
    curByte = 8'h00;
    fwdByte = 8'h00;
    fwdTag = 1'b0;
    forever begin
      @(posedge core_clk);
      #1;
      if (strobeLine === 1'b0) begin
        fwdByte = pdIn;
        fwdTag = autoFdLine;
        repeat (delayCyc) @(posedge core_clk);
        #1 busyIn = 1'b1;
        do @(posedge core_clk); while (strobeLine !== 1'b1);
        #1 busyIn = 1'b0;
        fwdCnt++;
      end else if (autoFdLine === 1'b0 && drvEn && revSent < revCnt) begin
        curByte = revItem[revSent][7:0];
        busyIn = revItem[revSent][8];
        repeat (2) @(posedge core_clk);
        #1 ackIn_n = 1'b0;
        do @(posedge core_clk); while (autoFdLine !== 1'b1);
        #1 ackIn_n = 1'b1;
        revSent++;
      end else if (drvEn) begin
        // idle: show the next reverse byte as plain pin levels
        curByte = revItem[revSent % 3][7:0];
      end
    end
  end
endmodule : ecp_periph_model

/* File: sim/ecp_port_mode_control_tb.sv */
// self-checking bench for the parallel port mode controller
`timescale 1ns/1ps

module ecp_port_mode_control_tb;
  import ecp_pkg::*;

  typedef struct packed {
    logic [2:0] wrMode;
    logic [2:0] expMode;
    logic expOe;
  } row_s;

  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [10:0] ioAddr = 11'h000;
  logic ioRd = 1'b0;
  logic ioWr = 1'b0;
  logic [7:0] ioWrData = 8'h00;
  logic [7:0] ioRdData, pdIn, pdOut, fwdByte, got;
  logic eppOptionEn = 1'b0;
  logic eppSelected, pdOe_n, busyIn, ackIn_n, fwdTag;
  logic strobeOut_n, strobeOe_n, autoFdOut_n, autoFdOe_n;
  logic initOut_n, initOe_n, selectInOut_n, selectInOe_n;
  logic strobeLine, autoFdLine;
  logic drvEn = 1'b0;
  logic [1:0] revCnt = 2'h0;
  logic [0:2][8:0] revItem = '{9'h000, 9'h000, 9'h000};
  logic [7:0] delayCyc = 8'h03;
  int fwdCnt, revSent, error_cnt = 0, checked = 0;
  row_s rows [12] = '{
    '{3'h1, 3'h1, 1'b0}, '{3'h4, 3'h4, 1'b0}, '{3'h6, 3'h4, 1'b0},
    '{3'h0, 3'h0, 1'b1}, '{3'h5, 3'h5, 1'b0}, '{3'h7, 3'h5, 1'b0},
    '{3'h1, 3'h1, 1'b0}, '{3'h7, 3'h7, 1'b0}, '{3'h2, 3'h7, 1'b0},
    '{3'h0, 3'h0, 1'b1}, '{3'h6, 3'h6, 1'b0}, '{3'h1, 3'h1, 1'b0}};

  always #12.5 core_clk = ~core_clk;
  // control lines have pull-ups when not driven
  assign strobeLine = strobeOe_n ? 1'b1 : strobeOut_n;
  assign autoFdLine = autoFdOe_n ? 1'b1 : autoFdOut_n;

  ecp_port_mode_control u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .ioAddr(ioAddr),
    .ioRd(ioRd), .ioWr(ioWr), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .eppOptionEn(eppOptionEn), .eppSelected(eppSelected), .pdIn(pdIn),
    .pdOut(pdOut), .pdOe_n(pdOe_n), .busyIn(busyIn), .ackIn_n(ackIn_n),
    .faultIn_n(1'b1), .slctIn(1'b0), .pErrorIn(1'b0),
    .strobeOut_n(strobeOut_n), .strobeOe_n(strobeOe_n),
    .autoFdOut_n(autoFdOut_n), .autoFdOe_n(autoFdOe_n),
    .initOut_n(initOut_n), .initOe_n(initOe_n),
    .selectInOut_n(selectInOut_n), .selectInOe_n(selectInOe_n));

  ecp_periph_model u_periph (
    .core_clk(core_clk), .strobeLine(strobeLine), .autoFdLine(autoFdLine),
    .pdOe_n(pdOe_n), .pdOut(pdOut), .drvEn(drvEn), .revCnt(revCnt),
    .revItem(revItem), .delayCyc(delayCyc), .busyIn(busyIn),
    .ackIn_n(ackIn_n), .pdIn(pdIn), .fwdByte(fwdByte), .fwdTag(fwdTag),
    .fwdCnt(fwdCnt), .revSent(revSent));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    checked++;
    if (act !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask : chk

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 ioWr = 1'b1;
    ioAddr = a;
    ioWrData = d;
    @(posedge core_clk);
    #1 ioWr = 1'b0;
  endtask : wr

  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1 ioRd = 1'b1;
    ioAddr = a;
    @(posedge core_clk);
    #1 ioRd = 1'b0;
    d = ioRdData;
  endtask : rd

  task automatic setMode(input logic [2:0] m);
    wr(OFS_XCTL, {m, 5'h04});
  endtask : setMode

  task automatic rdChk(input logic [10:0] a, input logic [7:0] exp);
    rd(a, got);
    chk(got, exp);
  endtask : rdChk

  // waits on the model's transfer counters with a bound
  task automatic waitCnt(input int target, input bit rev);
    int n;
    for (n = 0; n < 3000; n++) begin
      if ((rev ? revSent : fwdCnt) >= target) break;
      @(posedge core_clk);
    end
    if (n == 3000) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, n, target);
      report_and_stop();
    end
  endtask : waitCnt

  initial begin
    repeat (5) @(posedge core_clk);
    #1 reset_n = 1'b1;
    rdChk(OFS_XCTL, 8'h05);
    chk({7'h0, initOut_n}, 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      setMode(rows[i].wrMode);
      rdChk(OFS_XCTL, {rows[i].expMode, 5'h05});
      chk({7'h0, strobeOe_n}, {7'h0, rows[i].expOe});
      chk({4'h0, selectInOut_n, autoFdOe_n, selectInOe_n, initOe_n},
          {4'h1, rows[i].expOe, rows[i].expOe, 1'b0});
      chk({6'h0, strobeOut_n, autoFdOut_n}, 8'h03);
    end
    $display("test mode table done");
    setMode(MODE_TEST);
    for (int i = 0; i < 16; i++) wr(OFS_FIFO, 8'(i * 7 + 3));
    rdChk(OFS_XCTL, 8'hC6);
    wr(OFS_FIFO, 8'hEE);
    for (int i = 0; i < 16; i++) rdChk(OFS_FIFO, 8'(i * 7 + 3));
    rdChk(OFS_XCTL, 8'hC5);
    chk({7'h0, strobeOut_n}, 8'h01);
    $display("test fifo done");
    setMode(MODE_PS2);
    setMode(MODE_CFG);
    rdChk(OFS_FIFO, CFGA_VALUE);
    rdChk(OFS_CFGB, CFGB_VALUE);
    setMode(MODE_SPP);
    wr(OFS_CONTROL, 8'h20);
    repeat (2) @(posedge core_clk);
    chk({7'h0, pdOe_n}, 8'h00);
    setMode(MODE_PS2);
    repeat (2) @(posedge core_clk);
    chk({7'h0, pdOe_n}, 8'h00);
    wr(OFS_CONTROL, 8'h20);
    revItem[0] = 9'h096;
    drvEn = 1'b1;
    repeat (4) @(posedge core_clk);
    chk({7'h0, pdOe_n}, 8'h01);
    rdChk(OFS_DATA, 8'h96);
    setMode(MODE_SPP);
    repeat (2) @(posedge core_clk);
    chk({7'h0, pdOe_n}, 8'h00);
    setMode(MODE_TEST);
    wr(OFS_CONTROL, 8'h00);
    repeat (2) @(posedge core_clk);
    chk({7'h0, pdOe_n}, 8'h01);
    setMode(MODE_PS2);
    wr(OFS_CONTROL, 8'h00);
    drvEn = 1'b0;
    $display("test direction done");
    eppOptionEn = 1'b1;
    setMode(MODE_EPP);
    repeat (3) @(posedge core_clk);
    chk({7'h0, eppSelected}, 8'h01);
    #1 eppOptionEn = 1'b0;
    repeat (3) @(posedge core_clk);
    chk({7'h0, eppSelected}, 8'h00);
    setMode(MODE_PS2);
    $display("test epp done");
    setMode(MODE_ECP);
    wr(OFS_DATA, 8'h85);
    wr(OFS_FIFO, 8'h3C);
    waitCnt(1, 1'b0);
    chk(fwdByte, 8'h85);
    chk({7'h0, fwdTag}, 8'h00);
    waitCnt(2, 1'b0);
    chk(fwdByte, 8'h3C);
    chk({7'h0, fwdTag}, 8'h01);
    repeat (4) @(posedge core_clk);
    setMode(MODE_PS2);
    repeat (3) @(posedge core_clk);
    chk({6'h0, strobeOut_n, autoFdOut_n}, 8'h03);
    $display("test forward ecp done");
    delayCyc = 8'h1E;
    setMode(MODE_FIFO);
    wr(OFS_FIFO, 8'h5A);
    waitCnt(3, 1'b0);
    chk(fwdByte, 8'h5A);
    repeat (4) @(posedge core_clk);
    setMode(MODE_PS2);
    $display("test compatible fifo done");
    wr(OFS_CONTROL, 8'h20);
    revItem = '{9'h002, 9'h1A7, 9'h111};
    revCnt = 2'h3;
    drvEn = 1'b1;
    setMode(MODE_ECP);
    waitCnt(3, 1'b1);
    repeat (10) @(posedge core_clk);
    for (int i = 0; i < 3; i++) rdChk(OFS_FIFO, 8'hA7);
    rdChk(OFS_XCTL, 8'h64);
    setMode(MODE_PS2);
    repeat (3) @(posedge core_clk);
    chk({7'h0, autoFdOut_n}, 8'h01);
    rdChk(OFS_XCTL, 8'h25);
    wr(OFS_CONTROL, 8'h00);
    $display("test reverse ecp done");
    report_and_stop();
  end
endmodule : ecp_port_mode_control_tb
